// *** hw/vse_pkg.sv ***
// Package with register map, field layout and state encodings of the virtual SError unit
package vse_pkg;

  // Register word addresses (Avalon word index, byte address = 4 * index)
  localparam logic [5:0] ADDR_HYP_CTRL = 6'h00;
  localparam logic [5:0] ADDR_VSYN_64 = 6'h01;
  localparam logic [5:0] ADDR_VFSR_32 = 6'h02;
  localparam logic [5:0] ADDR_VDSYN_64 = 6'h03;
  localparam logic [5:0] ADDR_VDSYN_32 = 6'h04;
  localparam logic [5:0] ADDR_EL1_SYN = 6'h05;
  localparam logic [5:0] ADDR_DATA_FAULT_STATUS_32_32 = 6'h06;
  localparam logic [5:0] ADDR_DSYN_64 = 6'h07;
  localparam logic [5:0] ADDR_DSYN_32 = 6'h08;
  localparam logic [5:0] ADDR_REC_COUNT = 6'h09;
  localparam logic [5:0] ADDR_REC_SEL = 6'h0a;
  localparam logic [5:0] ADDR_EVENT = 6'h0b;
  localparam logic [5:0] ADDR_REC_CTRL = 6'h0c;
  localparam logic [5:0] ADDR_REC_STATUS = 6'h0d;
  localparam logic [5:0] ADDR_REC_MISC = 6'h0e;
  localparam logic [5:0] ADDR_NODE_CFG = 6'h0f;
  localparam logic [5:0] ADDR_HYP_SYN = 6'h10;

  // Control register bit positions
  localparam int CTRL_ROUTE_BIT = 0;
  localparam int CTRL_INJ64_BIT = 1;
  localparam int CTRL_INJ32_BIT = 2;
  localparam int CTRL_ROUTE32_BIT = 3;
  localparam int CTRL_STATE32_BIT = 4;
  localparam int CTRL_PEND_BIT = 8;

  // Event register bit positions (write one to trigger)
  localparam int EV_TAKE_BIT = 0;
  localparam int EV_MASK_BIT = 1;
  localparam int EV_BARRIER_BIT = 2;
  localparam int EV_PHYS_TAKE_BIT = 3;
  localparam int EV_PHYS_DEFER_BIT = 4;
  localparam int EV_REC_ERR_BIT = 5;

  // Syndrome field layout
  localparam int SYN_W = 25;
  localparam int SYN_IMPDEF_BIT = 24;
  localparam int DF_AET_LO = 14;
  localparam int DF_EXT_BIT = 12;
  localparam int DF_PEND_BIT = 31;
  localparam logic [31:0] DF_RELAX_MASK = 32'h0000_d000;
  localparam logic [31:0] HSR_RELAX_MASK = 32'h0000_0e00;
  localparam logic [31:0] DF_VIRT_BASE = 32'h0000_0211;

  // Error record window
  localparam int REC_NUM = 4;
  localparam int REC_IDX_W = 2;
  localparam logic [31:0] REC_COUNT_VAL = 32'h0000_0004;
  localparam logic [31:0] REC_V11_FMT = 32'h0000_0011;
  localparam logic [24:0] IMPDEF_SYN_VAL = 25'h100_0000;
  localparam logic [1:0] IMPDEF_AET_VAL = 2'h0;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Bus handler states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } vse_bus_t;

endpackage

// *** hw/vse_rec_mem.sv ***
`timescale 1ns/1ps
// Small memory holding the error-record words reached through the selection window
module vse_rec_mem
  import vse_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [REC_IDX_W+1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);

  // Record storage, four words per record
  logic [31:0] mem_ff [0:(REC_NUM*4)-1];

  // Write port and registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= RST_ZERO;
    end else begin
      if (we_i) begin
        mem_ff[addr_i] <= wdata_i;
      end
      rdata_o <= mem_ff[addr_i];
    end
  end

endmodule // vse_rec_mem

// *** hw/vse_syn_mux.sv ***
`timescale 1ns/1ps
// Combinational selection of the guest syndrome for a virtual error
module vse_syn_mux
  import vse_pkg::*;
(
  input wire logic impdef_i,
  input wire logic [31:0] vsyn64_i,
  input wire logic [31:0] vfsr32_i,
  output logic [24:0] esr_o,
  output logic [1:0] aet_o,
  output logic ext_o
);

  // Hypervisor value or fixed implementation value
  always_comb begin
    if (impdef_i) begin
      esr_o = IMPDEF_SYN_VAL;
      aet_o = IMPDEF_AET_VAL;
      ext_o = 1'b0;
    end else begin
      esr_o = vsyn64_i[SYN_W-1:0];
      aet_o = vfsr32_i[DF_AET_LO+1:DF_AET_LO];
      ext_o = vfsr32_i[DF_EXT_BIT];
    end
  end

endmodule // vse_syn_mux

// *** hw/vse_unit.sv ***
`timescale 1ns/1ps
// Virtual SError injection and syndrome register unit with Avalon-MM slave

module vse_unit
  import vse_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic IMPDEF_VSE_I,
  input wire logic IMPDEF_SYNC_I,
  input wire logic [31:0] PHYS_SYN_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic VSE_PENDING_O,
  output logic FAULT_IRQ_O,
  output logic RECOVERY_IRQ_O,
  output logic CRITICAL_IRQ_O,
  output logic INBAND_ERR_O
);

  // Byte-enable merge used by the virtual and deferred syndrome registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Software-visible state
  logic route_ff; // Routing of SError to hypervisor
  logic route32_ff; // 32-bit routing copy
  logic inj64_ff; // 64-bit inject bit
  logic inj32_ff; // 32-bit inject bit
  logic state32_ff; // Guest runs in 32-bit state
  logic [31:0] vsyn64_ff; // Virtual syndrome, 64-bit
  logic [31:0] vfsr32_ff; // Virtual fault status, 32-bit
  logic [31:0] vdsyn64_ff; // Virtual deferred syndrome, 64-bit
  logic [31:0] vdsyn32_ff; // Virtual deferred syndrome, 32-bit
  logic [31:0] el1syn_ff; // Guest exception syndrome
  logic [31:0] dfsr32_ff; // Guest data fault status
  logic [31:0] dsyn64_ff; // Deferred syndrome, 64-bit
  logic [31:0] dsyn32_ff; // Deferred syndrome, 32-bit
  logic [31:0] hypsyn_ff; // Hypervisor syndrome, 32-bit
  logic [REC_IDX_W-1:0] recsel_ff; // Selected record index
  logic [3:0] nodecfg_ff; // Interrupt selection of the node

  // Bus handler
  vse_bus_t bus_ff;
  logic [31:0] rd_mux; // Combinational read data
  logic wr_ok; // Write accepted this cycle
  logic rd_ok; // Read data registered this cycle, one before the answer
  logic [31:0] wdata; // Raw write data helper, no byte-enable merge
  logic pend; // Pending virtual error
  logic inject; // Selected inject bit
  logic [24:0] mux_esr;
  logic [1:0] mux_aet;
  logic mux_ext;
  logic rec_we;
  logic [REC_IDX_W+1:0] rec_addr;
  logic [31:0] rec_rdata;
  logic ev_take;
  logic ev_mask;
  logic ev_bar;
  logic ev_ptake;
  logic ev_pdef;
  logic ev_rec;

  // Write lands only at the edge where waitrequest is sampled low
  assign wr_ok = AVS_WRITE_I && (bus_ff == BUS_DONE);
  // Read data registered one edge before the answer edge
  assign rd_ok = AVS_READ_I && (bus_ff == BUS_WAIT);
  assign inject = state32_ff ? inj32_ff : inj64_ff;
  // Pending condition
  assign pend = ((state32_ff ? route32_ff : route_ff) && inject) || IMPDEF_VSE_I;
  assign wdata = AVS_WRITEDATA_I;

  // Event strobes written through the event register
  assign ev_take = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_TAKE_BIT] && pend;
  assign ev_mask = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_MASK_BIT];
  assign ev_bar = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_BARRIER_BIT];
  assign ev_ptake = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_PHYS_TAKE_BIT];
  assign ev_pdef = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_PHYS_DEFER_BIT];
  assign ev_rec = wr_ok && (AVS_ADDRESS_I == ADDR_EVENT) && wdata[EV_REC_ERR_BIT];

  // Syndrome source selection
  vse_syn_mux u_mux (
    .impdef_i(IMPDEF_VSE_I),
    .vsyn64_i(vsyn64_ff),
    .vfsr32_i(vfsr32_ff),
    .esr_o(mux_esr),
    .aet_o(mux_aet),
    .ext_o(mux_ext)
  );

  // Record window storage, addressed by the held selection
  assign rec_addr = {recsel_ff, AVS_ADDRESS_I == ADDR_REC_STATUS,
                     AVS_ADDRESS_I == ADDR_REC_MISC};
  assign rec_we = wr_ok && ((AVS_ADDRESS_I == ADDR_REC_STATUS) ||
                            (AVS_ADDRESS_I == ADDR_REC_MISC));
  vse_rec_mem u_rec (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .we_i(rec_we),
    .addr_i(rec_addr),
    .wdata_i(AVS_WRITEDATA_I),
    .rdata_o(rec_rdata)
  );

  // Bus sequencing: record word settles in WAIT, answer stands through DONE
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      bus_ff <= BUS_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      case (bus_ff)
        BUS_IDLE: begin
          if (AVS_READ_I || AVS_WRITE_I) begin
            bus_ff <= BUS_WAIT;
          end
        end
        BUS_WAIT: begin
          bus_ff <= BUS_DONE;
          AVS_WAITREQUEST_O <= 1'b0; // Answer in the next cycle
        end
        BUS_DONE: begin
          bus_ff <= BUS_IDLE;
          AVS_WAITREQUEST_O <= 1'b1; // Answer stands one cycle only
        end
        default: begin
          bus_ff <= BUS_IDLE;
          AVS_WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end

  // Read data decode
  always_comb begin
    if (AVS_ADDRESS_I == ADDR_HYP_CTRL) begin
      rd_mux = RST_ZERO;
      rd_mux[CTRL_ROUTE_BIT] = route_ff;
      rd_mux[CTRL_INJ64_BIT] = inj64_ff;
      rd_mux[CTRL_INJ32_BIT] = inj32_ff;
      rd_mux[CTRL_ROUTE32_BIT] = route32_ff;
      rd_mux[CTRL_STATE32_BIT] = state32_ff;
      rd_mux[CTRL_PEND_BIT] = pend;
    end else if (AVS_ADDRESS_I == ADDR_VSYN_64) begin
      rd_mux = vsyn64_ff;
    end else if (AVS_ADDRESS_I == ADDR_VFSR_32) begin
      rd_mux = vfsr32_ff;
    end else if (AVS_ADDRESS_I == ADDR_VDSYN_64) begin
      rd_mux = vdsyn64_ff;
    end else if (AVS_ADDRESS_I == ADDR_VDSYN_32) begin
      rd_mux = vdsyn32_ff;
    end else if (AVS_ADDRESS_I == ADDR_EL1_SYN) begin
      rd_mux = el1syn_ff;
    end else if (AVS_ADDRESS_I == ADDR_DATA_FAULT_STATUS_32_32) begin
      rd_mux = dfsr32_ff;
    end else if (AVS_ADDRESS_I == ADDR_DSYN_64) begin
      rd_mux = dsyn64_ff;
    end else if (AVS_ADDRESS_I == ADDR_DSYN_32) begin
      rd_mux = dsyn32_ff;
    end else if (AVS_ADDRESS_I == ADDR_HYP_SYN) begin
      rd_mux = hypsyn_ff;
    end else if (AVS_ADDRESS_I == ADDR_REC_COUNT) begin
      rd_mux = REC_COUNT_VAL;
    end else if (AVS_ADDRESS_I == ADDR_REC_SEL) begin
      rd_mux = {{(32-REC_IDX_W){1'b0}}, recsel_ff};
    end else if (AVS_ADDRESS_I == ADDR_REC_CTRL) begin
      rd_mux = REC_V11_FMT;
    end else if ((AVS_ADDRESS_I == ADDR_REC_STATUS) || (AVS_ADDRESS_I == ADDR_REC_MISC)) begin
      rd_mux = rec_rdata;
    end else if (AVS_ADDRESS_I == ADDR_NODE_CFG) begin
      rd_mux = {28'h0000000, nodecfg_ff};
    end else begin
      rd_mux = RST_ZERO; // Unmapped reads as zero
    end
  end

  // Read data register
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= RST_ZERO;
    end else if (rd_ok) begin
      AVS_READDATA_O <= rd_mux;
    end
  end

  // Hypervisor control bits; barrier clear loses to a software set
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      route_ff <= 1'b0;
      route32_ff <= 1'b0;
      inj64_ff <= 1'b0;
      inj32_ff <= 1'b0;
      state32_ff <= 1'b0;
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_HYP_CTRL)) begin
      route_ff <= wdata[CTRL_ROUTE_BIT];
      inj64_ff <= wdata[CTRL_INJ64_BIT];
      inj32_ff <= wdata[CTRL_INJ32_BIT];
      route32_ff <= wdata[CTRL_ROUTE32_BIT];
      state32_ff <= wdata[CTRL_STATE32_BIT];
    end else if ((ev_bar && ev_mask && pend && !IMPDEF_VSE_I) || ev_take) begin
      inj64_ff <= 1'b0;
      inj32_ff <= 1'b0;
    end
  end

  // Virtual syndrome registers, full width read/write
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      vsyn64_ff <= RST_ZERO;
      vfsr32_ff <= RST_ZERO;
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_VSYN_64)) begin
      vsyn64_ff <= be_merge(vsyn64_ff, wdata, AVS_BYTEENABLE_I);
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_VFSR_32)) begin
      vfsr32_ff <= be_merge(vfsr32_ff, wdata, AVS_BYTEENABLE_I);
    end
  end

  // Virtual deferred syndromes; masked barrier zeroes and flags pending
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      vdsyn64_ff <= RST_ZERO;
      vdsyn32_ff <= RST_ZERO;
    end else if (ev_bar && ev_mask && pend && (!IMPDEF_VSE_I || IMPDEF_SYNC_I)) begin
      if (state32_ff) begin
        vdsyn32_ff <= RST_ZERO | (32'h1 << DF_PEND_BIT);
      end else begin
        vdsyn64_ff <= RST_ZERO | (32'h1 << DF_PEND_BIT);
      end
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_VDSYN_64)) begin
      vdsyn64_ff <= be_merge(vdsyn64_ff, wdata, AVS_BYTEENABLE_I);
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_VDSYN_32)) begin
      vdsyn32_ff <= be_merge(vdsyn32_ff, wdata, AVS_BYTEENABLE_I);
    end
  end

  // Guest exception syndrome registers and hypervisor syndrome
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      el1syn_ff <= RST_ZERO;
      dfsr32_ff <= RST_ZERO;
      hypsyn_ff <= RST_ZERO;
    end else if (ev_take) begin
      if (state32_ff) begin
        dfsr32_ff <= DF_VIRT_BASE | ({30'h0, mux_aet} << DF_AET_LO)
                     | ({31'h0, mux_ext} << DF_EXT_BIT);
      end else begin
        el1syn_ff <= {7'h00, mux_esr};
      end
    end else if (ev_ptake) begin
      el1syn_ff <= {7'h00, PHYS_SYN_I[SYN_W-1:0]};
      dfsr32_ff <= PHYS_SYN_I & DF_RELAX_MASK;
      hypsyn_ff <= PHYS_SYN_I & HSR_RELAX_MASK;
    end
  end

  // Physical deferred syndromes, pending flag kept live
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dsyn64_ff <= RST_ZERO;
      dsyn32_ff <= RST_ZERO;
    end else if (ev_pdef) begin
      dsyn64_ff <= {1'b1, 6'h00, PHYS_SYN_I[SYN_W-1:0]};
      dsyn32_ff <= {1'b1, 15'h0000, PHYS_SYN_I[15:0] & (DF_RELAX_MASK[15:0]
                   | HSR_RELAX_MASK[15:0])};
    end else if (ev_bar && ev_mask && pend && state32_ff) begin
      dsyn32_ff <= vdsyn32_ff;
    end else if (ev_bar && ev_mask && pend) begin
      dsyn64_ff <= vdsyn64_ff;
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_DSYN_64)) begin
      dsyn64_ff <= be_merge(dsyn64_ff, wdata, AVS_BYTEENABLE_I);
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_DSYN_32)) begin
      dsyn32_ff <= be_merge(dsyn32_ff, wdata, AVS_BYTEENABLE_I);
    end
  end

  // Record selection and node interrupt configuration
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      recsel_ff <= '0;
      nodecfg_ff <= 4'h0;
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_REC_SEL)) begin
      recsel_ff <= wdata[REC_IDX_W-1:0];
    end else if (wr_ok && (AVS_ADDRESS_I == ADDR_NODE_CFG)) begin
      nodecfg_ff <= wdata[3:0];
    end
  end

  // Pending level and recorded-error signalling pulses
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      VSE_PENDING_O <= 1'b0;
      FAULT_IRQ_O <= 1'b0;
      RECOVERY_IRQ_O <= 1'b0;
      CRITICAL_IRQ_O <= 1'b0;
      INBAND_ERR_O <= 1'b0;
    end else begin
      VSE_PENDING_O <= pend;
      FAULT_IRQ_O <= ev_rec && nodecfg_ff[0];
      RECOVERY_IRQ_O <= ev_rec && nodecfg_ff[1];
      CRITICAL_IRQ_O <= ev_rec && nodecfg_ff[2];
      INBAND_ERR_O <= ev_rec && nodecfg_ff[3];
    end
  end

endmodule // vse_unit

// *** tb/vse_unit_monitor.sv ***
// Checker of port timing and fixed read values of the virtual SError unit
`timescale 1ns/1ps
module vse_unit_monitor
  import vse_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic IMPDEF_VSE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic VSE_PENDING_O,
  input wire logic FAULT_IRQ_O,
  input wire logic RECOVERY_IRQ_O,
  input wire logic CRITICAL_IRQ_O,
  input wire logic INBAND_ERR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic rd_ack; // Read answered in this cycle
  assign rd_ack = AVS_READ_I && !AVS_WAITREQUEST_O;
  wait_one_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
    else $error("answer without a request");
  cnt_read_a: assert property (rd_ack && AVS_ADDRESS_I == ADDR_REC_COUNT |->
    AVS_READDATA_O == REC_COUNT_VAL) else $error("record count wrong");
  fmt_read_a: assert property (rd_ack && AVS_ADDRESS_I == ADDR_REC_CTRL |->
    AVS_READDATA_O == REC_V11_FMT) else $error("record format wrong");
  pend_cause_a: assert property ($rose(VSE_PENDING_O) |-> $past(IMPDEF_VSE_I) ||
    $past(AVS_WRITE_I) || $past(AVS_WRITE_I, 2)) else $error("pending without cause");
  fault_pulse_a: assert property (FAULT_IRQ_O |=> !FAULT_IRQ_O)
    else $error("fault interrupt too long");
  recov_pulse_a: assert property (RECOVERY_IRQ_O |=> !RECOVERY_IRQ_O)
    else $error("recovery interrupt too long");
  crit_pulse_a: assert property (CRITICAL_IRQ_O |=> !CRITICAL_IRQ_O)
    else $error("critical interrupt too long");
  inband_pulse_a: assert property (INBAND_ERR_O |=> !INBAND_ERR_O)
    else $error("in-band response too long");
  // Main scenarios reached
  pend_c: cover property ($rose(VSE_PENDING_O));
  fault_c: cover property (FAULT_IRQ_O);
  read_c: cover property (rd_ack);
endmodule // vse_unit_monitor

bind vse_unit vse_unit_monitor mon (.CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .IMPDEF_VSE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .VSE_PENDING_O,
  .FAULT_IRQ_O, .RECOVERY_IRQ_O, .CRITICAL_IRQ_O, .INBAND_ERR_O);

// *** tb/vse_unit_tb_top.sv ***
// Self-checking bench of the virtual SError unit
`timescale 1ns/1ps
module vse_unit_tb_top;
  import vse_pkg::*;
  logic CLK_I, SYS_RST_I, AVS_READ_I, AVS_WRITE_I, IMPDEF_VSE_I, IMPDEF_SYNC_I;
  logic [5:0] AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, PHYS_SYN_I, AVS_READDATA_O, rd, v;
  logic [3:0] AVS_BYTEENABLE_I, irq_seen;
  logic AVS_WAITREQUEST_O, VSE_PENDING_O, FAULT_IRQ_O, RECOVERY_IRQ_O;
  logic CRITICAL_IRQ_O, INBAND_ERR_O, clr_irq;
  logic [31:0] rec_q[$]; // Model of the record words
  int mismatches, n_tests, seed, k;
  vse_unit dut (.CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .IMPDEF_VSE_I, .IMPDEF_SYNC_I, .PHYS_SYN_I,
    .AVS_READDATA_O, .AVS_WAITREQUEST_O, .VSE_PENDING_O, .FAULT_IRQ_O, .RECOVERY_IRQ_O,
    .CRITICAL_IRQ_O, .INBAND_ERR_O);
  // Clock at 100 MHz
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  // Sticky record of interrupt pulses
  always @(posedge CLK_I) begin
    if (clr_irq) irq_seen <= 4'h0;
    else irq_seen <= irq_seen | {INBAND_ERR_O, CRITICAL_IRQ_O, RECOVERY_IRQ_O, FAULT_IRQ_O};
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("wrong value waitrequest expected 0 seen %b", AVS_WAITREQUEST_O);
      finish_test();
    end
    rd = AVS_READDATA_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask
  // Read a register and compare the masked bits
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e & m, rd & m);
  endtask
  // Pending level, registered one edge after the accepting edge
  task automatic pend(input logic e);
    repeat (2) @(posedge CLK_I);
    chk("pending", {31'h0, e}, {31'h0, VSE_PENDING_O});
  endtask
  // Main sequence
  initial begin
    seed = 94;
    {AVS_READ_I, AVS_WRITE_I, IMPDEF_VSE_I, IMPDEF_SYNC_I, clr_irq} = 5'h0;
    AVS_ADDRESS_I = 6'h0;
    AVS_WRITEDATA_I = 32'h0;
    PHYS_SYN_I = 32'h0;
    AVS_BYTEENABLE_I = 4'hf;
    irq_seen = 4'h0;
    SYS_RST_I = 1'b1;
    repeat (3) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    // Reset contents, fixed words, refused places
    rdchk(ADDR_HYP_CTRL, 32'h0, 32'hffff_ffff);
    bus(1'b1, ADDR_REC_COUNT, 32'hffff_ffff);
    rdchk(ADDR_REC_COUNT, REC_COUNT_VAL, 32'hffff_ffff);
    rdchk(ADDR_REC_CTRL, REC_V11_FMT, 32'hffff_ffff);
    rdchk(6'h3f, 32'h0, 32'hffff_ffff);
    // Virtual syndrome read back, bits 24:0 compared
    for (k = 0; k < 3; k++) begin
      v = $random(seed);
      bus(1'b1, ADDR_VSYN_64, v);
      rdchk(ADDR_VSYN_64, v, 32'h1ff_ffff);
    end
    // Byte-enable write touches only the low byte
    AVS_BYTEENABLE_I <= 4'h1;
    bus(1'b1, ADDR_VSYN_64, ~v);
    AVS_BYTEENABLE_I <= 4'hf;
    v[7:0] = ~v[7:0];
    rdchk(ADDR_VSYN_64, v, 32'hffff_ffff);
    // Inject without routing, then routed, then taken
    bus(1'b1, ADDR_HYP_CTRL, 32'h2);
    pend(1'b0);
    bus(1'b1, ADDR_HYP_CTRL, 32'h3);
    pend(1'b1);
    bus(1'b1, ADDR_EVENT, 32'h1);
    rdchk(ADDR_EL1_SYN, v, 32'h1ff_ffff);
    rdchk(ADDR_HYP_CTRL, 32'h1, 32'h11f);
    // Taken in the 32-bit state
    v = $random(seed);
    bus(1'b1, ADDR_VFSR_32, v);
    bus(1'b1, ADDR_HYP_CTRL, 32'h1d);
    pend(1'b1);
    bus(1'b1, ADDR_EVENT, 32'h1);
    rdchk(ADDR_DATA_FAULT_STATUS_32_32, v, DF_RELAX_MASK);
    // Implementation source in both states
    for (k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_HYP_CTRL, k ? 32'h19 : 32'h1);
      IMPDEF_VSE_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      chk("pending", 32'h1, {31'h0, VSE_PENDING_O});
      bus(1'b1, ADDR_EVENT, 32'h1);
      IMPDEF_VSE_I <= 1'b0;
      if (k == 0) rdchk(ADDR_EL1_SYN, IMPDEF_SYN_VAL, 32'h100_0000);
      else rdchk(ADDR_DATA_FAULT_STATUS_32_32, {IMPDEF_AET_VAL, 14'h0}, DF_RELAX_MASK);
    end
    // Masked pending error at the barrier
    bus(1'b1, ADDR_VDSYN_64, 32'h0000_1234);
    bus(1'b1, ADDR_HYP_CTRL, 32'h3);
    bus(1'b1, ADDR_EVENT, 32'h6);
    rdchk(ADDR_VDSYN_64, 32'h8000_0000, 32'hffff_ffff);
    rdchk(ADDR_HYP_CTRL, 32'h1, 32'h7);
    // Physical take and defer
    PHYS_SYN_I <= $random(seed);
    bus(1'b1, ADDR_HYP_CTRL, 32'h0);
    bus(1'b1, ADDR_EVENT, 32'h8);
    rdchk(ADDR_EL1_SYN, PHYS_SYN_I, 32'h1ff_ffff);
    bus(1'b1, ADDR_EVENT, 32'h10);
    rdchk(ADDR_DSYN_64, PHYS_SYN_I, 32'h1ff_ffff);
    v = (PHYS_SYN_I & (DF_RELAX_MASK | HSR_RELAX_MASK)) | 32'h8000_0000;
    rdchk(ADDR_DSYN_32, v, 32'hffff_ffff);
    rdchk(ADDR_HYP_SYN, PHYS_SYN_I & HSR_RELAX_MASK, 32'hffff_ffff);
    // Synchronised implementation source at a masked barrier, 32-bit state
    bus(1'b1, ADDR_HYP_CTRL, 32'h19);
    IMPDEF_VSE_I <= 1'b1;
    IMPDEF_SYNC_I <= 1'b1;
    bus(1'b1, ADDR_EVENT, 32'h6);
    IMPDEF_VSE_I <= 1'b0;
    IMPDEF_SYNC_I <= 1'b0;
    rdchk(ADDR_VDSYN_32, 32'h8000_0000, 32'hffff_ffff);
    // Record window: fill each record, read back in reverse
    for (k = 0; k < REC_NUM; k++) begin
      rec_q.push_back($random(seed));
      bus(1'b1, ADDR_REC_SEL, k);
      bus(1'b1, ADDR_REC_STATUS, rec_q[k]);
      bus(1'b1, ADDR_REC_MISC, ~rec_q[k]);
    end
    for (k = REC_NUM - 1; k >= 0; k--) begin
      bus(1'b1, ADDR_REC_SEL, k);
      rdchk(ADDR_REC_SEL, k, 32'h3);
      rdchk(ADDR_REC_STATUS, rec_q[k], 32'hffff_ffff);
      rdchk(ADDR_REC_MISC, ~rec_q[k], 32'hffff_ffff);
    end
    // Recorded error raises the configured interrupts
    for (k = 0; k < 6; k++) begin
      v = (k < 2) ? {28'h0, {4{k[0]}}} : $random(seed);
      bus(1'b1, ADDR_NODE_CFG, v & 32'hf);
      clr_irq <= 1'b1;
      @(posedge CLK_I);
      clr_irq <= 1'b0;
      bus(1'b1, ADDR_EVENT, 32'h20);
      repeat (3) @(posedge CLK_I);
      chk("interrupts", v & 32'hf, {28'h0, irq_seen});
    end
    finish_test();
  end
endmodule // vse_unit_tb_top
